// >>> hw/udi_flags.sv
// interrupt flag and mask logic of a full-speed usb device controller
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "udi_params.svh"
// Functional notes
// - mask bits 15..8, one clears output gating
// - nak flag sets on non-zero endpoint nak
// - writing one to nak flag clears nak register
// - endpoint-done flag sets on non-zero endpoint transfer
// - writing one clears per-endpoint completion register
// - endpoint-zero flag sets on ep0 transfer done
// - frame flag on sof or counted frame
// - zero-length flag sets on empty packet
// - writing one clears per-endpoint zero-length register
// - control-read status packet leaves zero-length flag
// - status-done flag on ep0 status stage done
// - status-packet flag on control-read status packet
// - zero-length write end uses status-packet flag
// - setup flag on ep0 setup token
// - per-endpoint bits 7..1 set on completion
// - endpoint mask hides shared output, bit sets
module udi_flags
  import udi_pkg::*;
#(
  parameter int NUM_EP = 8,
  parameter int FRAME_CYCLES = `UDI_FRAME_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // protocol engine events, one-cycle pulses
  input wire logic [7:0] ev_nak_ep,
  input wire logic [7:0] ev_done_ep,
  input wire logic [7:0] ev_zlen_ep,
  input wire logic ev_sof_token,
  input wire logic ev_ctrl_read_status,
  input wire logic ev_status_done,
  input wire logic ev_status_pkt,
  input wire logic ev_setup,
  // dedicated interrupt outputs
  output logic nak_irq_out,
  output logic endpoint_irq_out,
  output logic control_endpoint_irq_out,
  output logic sof_irq_out,
  output logic zero_length_irq_out,
  output logic status_irq_out,
  output logic status_pkt_irq_out,
  output logic setup_irq_out,
  // summary interrupt
  output logic irq
);
  initial begin
    if (NUM_EP != 8) begin
      $error("only eight endpoints are supported");
    end
  end
  typedef struct packed {
    udi_bus_state_t bus;
    logic [31:0] rdata;
    udi_byte_t flags;
    udi_byte_t masks;
    udi_byte_t ep_done;
    udi_byte_t ep_mask;
    udi_byte_t nak;
    udi_byte_t nak_mask;
    udi_byte_t zlen;
    logic create_sof;
    udi_byte_t irq_stat;
    udi_byte_t irq_mask;
    udi_byte_t pins;
    logic irq;
  } udi_state_t;
  udi_state_t state_reg;
  udi_state_t state_next;
  logic frame_tick;
  logic [7:0] set_flags;
  logic [7:0] clr_flags;
  logic [7:0] wbyte;
  logic [7:0] gate;
  logic wr;
  logic rd;
  udi_frame_timer #(
    .CYCLES(FRAME_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .enable(state_reg.create_sof),
    .tick(frame_tick)
  );
  always_comb begin
    state_next = state_reg;
    wr = 1'b0;
    rd = 1'b0;
    wbyte = wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00;
    clr_flags = 8'h00;
    set_flags = 8'h00;
    // event sources of the main flags
    set_flags[`UDI_BIT_NAK] = |ev_nak_ep[7:1];
    set_flags[`UDI_BIT_EP] = |ev_done_ep[7:1];
    set_flags[`UDI_BIT_EP0] = ev_done_ep[0];
    if (state_reg.create_sof) begin
      set_flags[`UDI_BIT_SOF] = frame_tick;
    end else begin
      set_flags[`UDI_BIT_SOF] = ev_sof_token;
    end
    set_flags[`UDI_BIT_ZLEN] = (|ev_zlen_ep) & ~ev_ctrl_read_status;
    set_flags[`UDI_BIT_STATUS] = ev_status_done;
    set_flags[`UDI_BIT_STATUS_PKT] = ev_status_pkt;
    set_flags[`UDI_BIT_SETUP] = ev_setup;
    // wishbone: ack one cycle after request, then drop
    case (state_reg.bus)
      UDI_BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_next.bus = UDI_BUS_ACK;
          wr = wb_we_i;
          rd = !wb_we_i;
        end
      end
      UDI_BUS_ACK: begin
        state_next.bus = UDI_BUS_IDLE;
      end
      default: begin
        state_next.bus = UDI_BUS_IDLE;
      end
    endcase
    if (wr) begin
      case (wb_adr_i)
        `UDI_OFS_FLAGS: begin
          clr_flags = wbyte;
          if (wb_sel_i[1]) begin
            state_next.masks = wb_dat_i[15:8];
          end
        end
        `UDI_OFS_EP_DONE: state_next.ep_done = state_reg.ep_done & ~wbyte;
        `UDI_OFS_EP_MASK: state_next.ep_mask = wbyte;
        `UDI_OFS_NAK: state_next.nak = state_reg.nak & ~wbyte;
        `UDI_OFS_NAK_MASK: state_next.nak_mask = wbyte;
        `UDI_OFS_ZLEN: state_next.zlen = state_reg.zlen & ~wbyte;
        `UDI_OFS_SOF_CFG: state_next.create_sof = wbyte[0];
        `UDI_OFS_IRQ_STAT: state_next.irq_stat = state_reg.irq_stat & ~wbyte;
        `UDI_OFS_IRQ_MASK: state_next.irq_mask = wbyte;
        default: begin
        end
      endcase
    end
    // clearing the summary flags empties the per-endpoint registers
    if (clr_flags[`UDI_BIT_NAK]) begin
      state_next.nak = 8'h00;
    end
    if (clr_flags[`UDI_BIT_EP]) begin
      state_next.ep_done = 8'h00;
    end
    if (clr_flags[`UDI_BIT_ZLEN]) begin
      state_next.zlen = 8'h00;
    end
    // events win over clears
    state_next.nak = state_next.nak | {ev_nak_ep[7:1], 1'b0};
    state_next.ep_done = state_next.ep_done | {ev_done_ep[7:1], 1'b0};
    if (!ev_ctrl_read_status) begin
      state_next.zlen = state_next.zlen | ev_zlen_ep;
    end
    state_next.flags = (state_reg.flags & ~clr_flags) | set_flags;
    state_next.irq_stat = state_next.irq_stat | set_flags;
    // read data
    if (rd) begin
      case (wb_adr_i)
        `UDI_OFS_FLAGS: state_next.rdata = {16'h0000, state_reg.masks, state_reg.flags};
        `UDI_OFS_EP_DONE: state_next.rdata = {24'h00_0000, state_reg.ep_done};
        `UDI_OFS_EP_MASK: state_next.rdata = {24'h00_0000, state_reg.ep_mask};
        `UDI_OFS_NAK: state_next.rdata = {24'h00_0000, state_reg.nak};
        `UDI_OFS_NAK_MASK: state_next.rdata = {24'h00_0000, state_reg.nak_mask};
        `UDI_OFS_ZLEN: state_next.rdata = {24'h00_0000, state_reg.zlen};
        `UDI_OFS_SOF_CFG: state_next.rdata = {31'h0000_0000, state_reg.create_sof};
        `UDI_OFS_IRQ_STAT: state_next.rdata = {24'h00_0000, state_reg.irq_stat};
        `UDI_OFS_IRQ_MASK: state_next.rdata = {24'h00_0000, state_reg.irq_mask};
        default: state_next.rdata = 32'h0000_0000;
      endcase
    end else if (state_reg.bus == UDI_BUS_ACK) begin
      state_next.rdata = 32'h0000_0000;
    end
    // dedicated pins: flag set and mask clear
    gate = state_next.flags & ~state_next.masks;
    // shared endpoint pins also need an unmasked endpoint bit
    gate[`UDI_BIT_EP] = gate[`UDI_BIT_EP]
      & (|(state_next.ep_done & ~state_next.ep_mask));
    gate[`UDI_BIT_ZLEN] = gate[`UDI_BIT_ZLEN]
      & (|(state_next.zlen & ~state_next.ep_mask));
    gate[`UDI_BIT_NAK] = gate[`UDI_BIT_NAK]
      & (|(state_next.nak & ~state_next.nak_mask));
    state_next.pins = gate;
    state_next.irq = |(state_next.irq_stat & ~state_next.irq_mask);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
      state_reg.bus <= UDI_BUS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  assign wb_ack_o = (state_reg.bus == UDI_BUS_ACK);
  assign wb_dat_o = state_reg.rdata;
  assign nak_irq_out = state_reg.pins[`UDI_BIT_NAK];
  assign endpoint_irq_out = state_reg.pins[`UDI_BIT_EP];
  assign control_endpoint_irq_out = state_reg.pins[`UDI_BIT_EP0];
  assign sof_irq_out = state_reg.pins[`UDI_BIT_SOF];
  assign zero_length_irq_out = state_reg.pins[`UDI_BIT_ZLEN];
  assign status_irq_out = state_reg.pins[`UDI_BIT_STATUS];
  assign status_pkt_irq_out = state_reg.pins[`UDI_BIT_STATUS_PKT];
  assign setup_irq_out = state_reg.pins[`UDI_BIT_SETUP];
  assign irq = state_reg.irq;
endmodule : udi_flags
`default_nettype wire

// >>> hw/udi_params.svh
// register offsets, field positions and reset values of the usb interrupt flag block
`ifndef UDI_PARAMS_SVH
`define UDI_PARAMS_SVH
`define UDI_OFS_FLAGS 8'h00
`define UDI_OFS_EP_DONE 8'h04
`define UDI_OFS_EP_MASK 8'h08
`define UDI_OFS_NAK 8'h0C
`define UDI_OFS_NAK_MASK 8'h10
`define UDI_OFS_ZLEN 8'h14
`define UDI_OFS_SOF_CFG 8'h18
`define UDI_OFS_IRQ_STAT 8'h1C
`define UDI_OFS_IRQ_MASK 8'h20
`define UDI_FLAG_LSB 0
`define UDI_MASK_LSB 8
`define UDI_BIT_NAK 7
`define UDI_BIT_EP 6
`define UDI_BIT_EP0 5
`define UDI_BIT_SOF 4
`define UDI_BIT_ZLEN 3
`define UDI_BIT_STATUS 2
`define UDI_BIT_STATUS_PKT 1
`define UDI_BIT_SETUP 0
`define UDI_RST_BYTE 8'h00
`define UDI_FRAME_TIME_NS 1000000
`define UDI_CLK_PERIOD_NS 10
`define UDI_FRAME_CYCLES (`UDI_FRAME_TIME_NS / `UDI_CLK_PERIOD_NS)
`endif

// >>> hw/udi_pkg.sv
// types of the usb interrupt flag block
package udi_pkg;
  typedef enum logic [1:0] {
    UDI_BUS_IDLE = 2'b00,
    UDI_BUS_ACK = 2'b01
  } udi_bus_state_t;
  typedef logic [7:0] udi_byte_t;
endpackage : udi_pkg

// >>> hw/udi_frame_timer.sv
// frame period counter for the self-generated frame mode
`timescale 1ns/1ns
`default_nettype none
module udi_frame_timer #(
  parameter int CYCLES = 100000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic enable,
  // event
  output logic tick
);
  initial begin
    if (CYCLES < 2) begin
      $error("frame cycles too small");
    end
  end
  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } udi_timer_state_t;
  udi_timer_state_t state_reg;
  udi_timer_state_t state_next;
  always_comb begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!enable) begin
      state_next.count = 32'h0000_0000;
    end else if (state_reg.count == 32'(CYCLES - 1)) begin
      state_next.count = 32'h0000_0000;
      state_next.tick = 1'b1;
    end else begin
      state_next.count = state_reg.count + 32'h0000_0001;
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign tick = state_reg.tick;
endmodule : udi_frame_timer
`default_nettype wire

// >>> sim/udi_engine_model.sv
// protocol engine model that pulses the event lines
`timescale 1ns/1ns
`default_nettype none
module udi_engine_model (
  // clock
  input wire logic clock,
  // event pulses
  output logic [7:0] nak,
  output logic [7:0] done,
  output logic [7:0] zlen,
  output logic sof,
  output logic crs,
  output logic sdone,
  output logic spkt,
  output logic setup
);
  initial {nak, done, zlen, sof, crs, sdone, spkt, setup} = '0;
  // one-cycle pulse of event kind k on endpoints m, kind 5 always on endpoint 0
  task automatic fire(input int k, input logic [7:0] m, input logic q);
    @(posedge clock);
    nak <= k == 7 ? m : 8'h00;
    done <= k == 6 ? m : k == 5 ? 8'h01 : 8'h00;
    zlen <= k == 3 ? m : 8'h00;
    crs <= q;
    sof <= k == 4;
    sdone <= k == 2;
    spkt <= k == 1;
    setup <= k == 0;
    @(posedge clock);
    {nak, done, zlen, sof, crs, sdone, spkt, setup} <= '0;
  endtask : fire
endmodule : udi_engine_model
`default_nettype wire

// >>> sim/udi_flags_monitor.sv
// checker for the usb interrupt flag block
`timescale 1ns/1ns
`default_nettype none
module udi_flags_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // events and pins
  input wire logic [7:0] ev_nak_ep,
  input wire logic ev_setup,
  input wire logic setup_irq_out,
  input wire logic nak_irq_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not idle");
  property p_setup_rise;
    $rose(setup_irq_out) |-> $past(ev_setup) || $past(wb_cyc_i) || $past(wb_cyc_i, 2);
  endproperty
  a_setup_rise: assert property (p_setup_rise) else $error("setup pin cause");
  property p_setup_fall; $fell(setup_irq_out) |-> $past(wb_cyc_i) || $past(wb_cyc_i, 2); endproperty
  a_setup_fall: assert property (p_setup_fall) else $error("setup pin fell");
  property p_nak_rise;
    $rose(nak_irq_out) |-> $past(|ev_nak_ep[7:1]) || $past(wb_cyc_i) || $past(wb_cyc_i, 2);
  endproperty
  a_nak_rise: assert property (p_nak_rise) else $error("nak pin cause");
  property p_setup_hold;
    !wb_cyc_i && !$past(wb_cyc_i) && !ev_setup |=> $stable(setup_irq_out);
  endproperty
  a_setup_hold: assert property (p_setup_hold) else $error("setup pin moved");
  property p_nak_hold; nak_irq_out && !wb_cyc_i && !$past(wb_cyc_i) |=> nak_irq_out; endproperty
  a_nak_hold: assert property (p_nak_hold) else $error("nak pin dropped");
endmodule : udi_flags_monitor
bind udi_flags udi_flags_monitor u_mon (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
  .wb_ack_o, .ev_nak_ep, .ev_setup, .setup_irq_out, .nak_irq_out);
`default_nettype wire

// >>> sim/udi_flags_tb.sv
// self-checking testbench of the usb interrupt flag block
`timescale 1ns/1ns
`default_nettype none
module udi_flags_tb;
  logic clock = 0, rst = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, ra;
  logic [31:0] dat = 0, v, q[$];
  wire [31:0] rdat;
  wire ack, sof, crs, sdone, spkt, setup, irq_o;
  wire [7:0] nak, done, zlen, pins;
  int errors = 0, check_count = 0, seed = 6762;
  initial forever #5 clock = ~clock;
  udi_engine_model u_eng (.clock(clock), .nak(nak), .done(done), .zlen(zlen), .sof(sof),
    .crs(crs), .sdone(sdone), .spkt(spkt), .setup(setup));
  udi_flags #(.FRAME_CYCLES(20)) dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ev_nak_ep(nak), .ev_done_ep(done), .ev_zlen_ep(zlen),
    .ev_sof_token(sof), .ev_ctrl_read_status(crs), .ev_status_done(sdone),
    .ev_status_pkt(spkt), .ev_setup(setup), .nak_irq_out(pins[7]),
    .endpoint_irq_out(pins[6]), .control_endpoint_irq_out(pins[5]), .sof_irq_out(pins[4]),
    .zero_length_irq_out(pins[3]), .status_irq_out(pins[2]), .status_pkt_irq_out(pins[1]),
    .setup_irq_out(pins[0]), .irq(irq_o));
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : cmp
  task test_done;
    cmp("pending reads", 0, q.size());
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    @(posedge clock);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      test_done();
    end
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q.push_back(e);
    wb(0, a, 0);
  endtask : rd
  task automatic pin(int k, logic e);
    @(posedge clock);
    #1 cmp("pin", e, pins[k]);
  endtask : pin
  task automatic irq_chk(logic e);
    @(posedge clock);
    #1 cmp("irq", e, irq_o);
  endtask : irq_chk
  always @(posedge clock) if (ack === 1'b1 && !we && q.size()) cmp("read", q.pop_front(), rdat);
  initial begin
    repeat (5) @(posedge clock);
    rst <= 0;
    for (int i = 0; i < 10; i++) rd(i * 4, 0);
    wb(1, 8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 0);
    $display("reset and map test done");
    for (int k = 0; k < 8; k++) begin
      ra = k == 7 ? 8'h0C : k == 6 ? 8'h04 : 8'h14;
      u_eng.fire(k, 8'h08, 0);
      pin(k, 1);
      rd(0, 1 << k);
      if (k inside {3, 6, 7}) rd(ra, 8);
      wb(1, 0, 1 << (k + 8));
      pin(k, 0);
      wb(1, 0, 1 << k);
      rd(0, 0);
      if (k inside {3, 6, 7}) rd(ra, 0);
    end
    $display("flag test done");
    u_eng.fire(7, 8'h01, 0);
    u_eng.fire(3, 8'h04, 1);
    rd(0, 0);
    rd(8'h14, 0);
    wb(1, 8'h08, 8);
    u_eng.fire(6, 8'h08, 0);
    pin(6, 0);
    rd(4, 8);
    wb(1, 0, 32'h0000_0040);
    wb(1, 8'h08, 0);
    $display("qualifier and endpoint mask test done");
    wb(1, 8'h18, 1);
    repeat (25) @(posedge clock);
    wb(1, 8'h18, 0);
    rd(0, 32'h0000_0010);
    wb(1, 0, 32'h0000_0010);
    v = $random(seed) & 32'h0000_FF00;
    wb(1, 0, v);
    rd(0, v);
    v = $random(seed) & 32'h0000_00FF;
    wb(1, 8'h08, v);
    rd(8'h08, v);
    $display("frame and random test done");
    irq_chk(1);
    rd(8'h1C, 32'h0000_00FF);
    wb(1, 8'h20, 32'h0000_00FF);
    irq_chk(0);
    wb(1, 8'h1C, 32'h0000_00FF);
    wb(1, 8'h20, 0);
    rd(8'h1C, 0);
    irq_chk(0);
    $display("summary interrupt test done");
    test_done();
  end
endmodule : udi_flags_tb
`default_nettype wire
